/* src/ldms_defs.vh */
// constants for the led driver mode sequencer
`ifndef LDMS_DEFS_VH
`define LDMS_DEFS_VH
// register indices
`define LDMS_ADDR_CTRL 8'h10
`define LDMS_ADDR_VOUT 8'h0d
// control register fields
`define LDMS_CTRL_RUN 0
`define LDMS_CTRL_BOOST 1
`define LDMS_CTRL_ALOAD 2
// reset values
`define LDMS_CTRL_RST 8'h04
`define LDMS_VOUT_RST 8'h08
// voltage clamp limits
`define LDMS_VOUT_MIN 8'h08
`define LDMS_VOUT_MAX 8'h14
// timing, ms and oscillator rate
`define LDMS_STARTUP_MS 10
`define LDMS_SOFTST_MS 20
`define LDMS_CLK_KHZ 50000
// mode state codes
`define LDMS_ST_RESET 3'h0
`define LDMS_ST_STBY 3'h1
`define LDMS_ST_START 3'h2
`define LDMS_ST_SOFT 3'h3
`define LDMS_ST_NORM 3'h4
`endif

/* src/ldms_delay.v */
// delay counter that raises done after a programmed number of cycles and holds it while run stays high
module ldms_delay #(
  parameter WIDTH = 20,
  parameter [WIDTH-1:0] COUNT = 20'd1000
) (
  // clocking
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // control
  input wire run_i,
  output wire done_o
);
  reg [WIDTH-1:0] cnt_reg;
  // counter clears whenever run drops so each entry restarts it
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (!run_i) begin
        cnt_reg <= {WIDTH{1'b0}};
      end else if (!done_o) begin
        cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
  assign done_o = run_i && (cnt_reg >= COUNT - {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // ldms_delay

/* src/ldms_seq.v */
// operating mode sequencer and boost digital control
`include "ldms_defs.vh"
module ldms_seq #(
  parameter STARTUP_CYC = `LDMS_STARTUP_MS * `LDMS_CLK_KHZ,
  parameter SOFTST_CYC = `LDMS_SOFTST_MS * `LDMS_CLK_KHZ
) (
  // clocking and reset
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  // reset sources
  input wire external_reset_low_n_i,
  input wire por_i,
  // thermal event
  input wire thermal_shutdown_i,
  // register write/read port from the serial interface
  input wire wr_en_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // mode and boost control outputs
  output reg [2:0] mode_o,
  output reg blocks_on_o,
  output reg boost_on_o,
  output reg boost_soft_o,
  output reg aload_on_o,
  output reg led_enable_o,
  output reg [7:0] vout_eff_o
);
  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  reg [7:0] ctrl_reg;
  reg [7:0] vout_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg boost_prev_reg;
  wire run_request;
  wire boost_en;
  wire aload_en;
  wire any_reset;
  wire start_done;
  wire soft_done;
  reg [7:0] vout_clamp;
  reg [7:0] rdata_next;
  // output decode values, registered below
  reg blocks_next;
  reg boost_next;
  reg soft_next;
  reg aload_next;
  reg led_next;
  // write decode and timer run terms
  wire wr_take;
  wire wr_ctrl_hit;
  wire wr_vout_hit;
  wire start_run;
  wire soft_run;
  assign run_request = ctrl_reg[`LDMS_CTRL_RUN];
  assign boost_en = ctrl_reg[`LDMS_CTRL_BOOST];
  assign aload_en = ctrl_reg[`LDMS_CTRL_ALOAD];
  assign any_reset = rst_i || !external_reset_low_n_i || por_i;
  // write strobe qualified by the clock enable; reset wins below
  assign wr_take = ce_i && wr_en_i;
  assign wr_ctrl_hit = wr_take && (addr_i == `LDMS_ADDR_CTRL);
  assign wr_vout_hit = wr_take && (addr_i == `LDMS_ADDR_VOUT);
  // timer run conditions
  // a thermal event stops and clears the startup timer
  assign start_run = (state_reg == `LDMS_ST_START) && !thermal_shutdown_i;
  assign soft_run = (state_reg == `LDMS_ST_SOFT);

  //--------------------------------------------------------------
  // register writes
  //--------------------------------------------------------------
  // defaults in reset; run bit clears
  // writes accepted while ce_i is high and no reset source is active; vout takes the whole byte, ctrl only bits 2:0
  always @(posedge clk_sys_i) begin
    if (any_reset) begin
      ctrl_reg <= `LDMS_CTRL_RST;
      vout_reg <= `LDMS_VOUT_RST;
    end else begin
      // upper control bits are not implemented and read as zero
      if (wr_ctrl_hit) begin
        ctrl_reg <= {5'h00, wdata_i[2:0]};
      end
      if (wr_vout_hit) begin
        vout_reg <= wdata_i;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_next = 8'h00;
    case (addr_i)
      `LDMS_ADDR_CTRL: rdata_next = ctrl_reg;
      `LDMS_ADDR_VOUT: rdata_next = vout_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data register also returns to zero in reset
  always @(posedge clk_sys_i) begin
    if (any_reset) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rdata_next;
    end
  end

  //--------------------------------------------------------------
  // delay timers
  //--------------------------------------------------------------
  // startup delay on the oscillator clock
  ldms_delay #(
    .WIDTH(24),
    .COUNT(STARTUP_CYC[23:0])
  ) u_start_dly (
    .clk_sys_i(clk_sys_i),
    .rst_i(any_reset),
    .ce_i(ce_i),
    .run_i(start_run),
    .done_o(start_done)
  );
  ldms_delay #(
    .WIDTH(24),
    .COUNT(SOFTST_CYC[23:0])
  ) u_soft_dly (
    .clk_sys_i(clk_sys_i),
    .rst_i(any_reset),
    .ce_i(ce_i),
    .run_i(soft_run),
    .done_o(soft_done)
  );

  //--------------------------------------------------------------
  // mode state machine
  //--------------------------------------------------------------
  // next state; thermal event sends any running mode back to startup
  always @* begin
    state_next = state_reg;
    case (state_reg)
      // leave reset for standby once sources drop
      `LDMS_ST_RESET: state_next = `LDMS_ST_STBY;
      `LDMS_ST_STBY: begin
        if (run_request) begin
          state_next = `LDMS_ST_START;
        end
      end
      `LDMS_ST_START: begin
        if (!run_request) begin
          state_next = `LDMS_ST_STBY;
        end else if (start_done && !thermal_shutdown_i) begin
          // boost on decides soft-start or normal
          state_next = boost_en ? `LDMS_ST_SOFT : `LDMS_ST_NORM;
        end
      end
      `LDMS_ST_SOFT: begin
        if (!run_request) begin
          state_next = `LDMS_ST_STBY;
        end else if (thermal_shutdown_i) begin
          state_next = `LDMS_ST_START;
        // boost dropped during soft-start: skip to normal
        end else if (soft_done || !boost_en) begin
          state_next = `LDMS_ST_NORM;
        end
      end
      `LDMS_ST_NORM: begin
        if (!run_request) begin
          state_next = `LDMS_ST_STBY;
        end else if (thermal_shutdown_i) begin
          state_next = `LDMS_ST_START;
        end else if (boost_en && !boost_prev_reg) begin
          state_next = `LDMS_ST_SOFT;
        end
      end
      default: state_next = `LDMS_ST_RESET;
    endcase
  end

  // state register; reset is forced regardless of state
  always @(posedge clk_sys_i) begin
    if (any_reset) begin
      state_reg <= `LDMS_ST_RESET;
      boost_prev_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      boost_prev_reg <= boost_en;
    end
  end

  //--------------------------------------------------------------
  // voltage clamp
  //--------------------------------------------------------------
  // clamp the setting to 8..20
  always @* begin
    vout_clamp = vout_reg;
    // below the floor is used as 8 V
    if (vout_reg < `LDMS_VOUT_MIN) begin
      vout_clamp = `LDMS_VOUT_MIN;
    // above the ceiling is used as 20 V
    end else if (vout_reg > `LDMS_VOUT_MAX) begin
      vout_clamp = `LDMS_VOUT_MAX;
    end
  end

  //--------------------------------------------------------------
  // output decode
  //--------------------------------------------------------------
  // per-mode output levels; a default keeps unknown codes all off
  always @* begin
    blocks_next = 1'b0;
    boost_next = 1'b0;
    soft_next = 1'b0;
    aload_next = 1'b0;
    led_next = 1'b0;
    case (state_reg)
      `LDMS_ST_RESET: begin
        blocks_next = 1'b0;
      end
      `LDMS_ST_STBY: begin
        blocks_next = 1'b0;
      end
      // startup powers the internal blocks only
      `LDMS_ST_START: begin
        blocks_next = 1'b1;
      end
      // soft-start: low current boost, leds held off
      `LDMS_ST_SOFT: begin
        blocks_next = 1'b1;
        boost_next = boost_en;
        soft_next = 1'b1;
        // discharge only while the converter runs
        aload_next = aload_en && boost_en;
        led_next = 1'b0;
      end
      // normal: converter follows its bit, leds permitted
      `LDMS_ST_NORM: begin
        blocks_next = 1'b1;
        boost_next = boost_en;
        aload_next = aload_en && boost_en;
        // control values act once startup is over
        led_next = 1'b1;
      end
      // unused codes: all off
      default: begin
        blocks_next = 1'b0;
      end
    endcase
  end

  //--------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------
  // registered so the analog side never sees decode glitches;
  // costs one cycle of latency after each state change
  always @(posedge clk_sys_i) begin
    if (any_reset) begin
      mode_o <= `LDMS_ST_RESET;
      blocks_on_o <= 1'b0;
      boost_on_o <= 1'b0;
      boost_soft_o <= 1'b0;
      aload_on_o <= 1'b0;
      led_enable_o <= 1'b0;
      vout_eff_o <= `LDMS_VOUT_MIN;
    end else if (ce_i) begin
      mode_o <= state_reg;
      blocks_on_o <= blocks_next;
      boost_on_o <= boost_next;
      boost_soft_o <= soft_next;
      aload_on_o <= aload_next;
      // leds stay off until normal mode
      led_enable_o <= led_next;
      vout_eff_o <= vout_clamp;
    end
  end
endmodule // ldms_seq

/* verification/ldms_host.sv */
// host model writing and reading the sequencer registers
module ldms_host (
  // clock
  input wire clk_sys_i,
  // register port
  output logic wr_en_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00,
  input wire [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // one byte per strobe; idle data inverted so stale bytes never match
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys_i);
    {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clk_sys_i);
    wr_en_o = 1'b0;
    wdata_o = ~d;
  endtask
  // read data lands one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    addr_o = a;
    @(negedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule // ldms_host

/* verification/ldms_seq_sva.sv */
// concurrent checks on the mode sequencer ports
module ldms_seq_sva #(parameter SOFTST_CYC = 30) (
  // clock, reset, inputs and the read data output
  input wire clk_sys_i, rst_i, ce_i, external_reset_low_n_i,
  input wire por_i, thermal_shutdown_i, wr_en_i,
  input wire [7:0] addr_i, wdata_i, rdata_o,
  // outputs
  input wire [2:0] mode_o,
  input wire blocks_on_o, boost_on_o, boost_soft_o, aload_on_o,
  input wire led_enable_o,
  input wire [7:0] vout_eff_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // writes the design may take
  wire take = ce_i && external_reset_low_n_i && !por_i && wr_en_i;
  wire wc = take && addr_i == 8'h10;
  wire wv = take && addr_i == 8'h0d;
  logic [2:0] last_reg;
  logic [31:0] run_reg;
  // enabled cycles spent in the present mode, restarts on any change
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      last_reg <= mode_o;
      run_reg <= (mode_o == last_reg) ? run_reg + 32'h1 : 32'h0;
    end
  end
  function automatic [7:0] clamp(input [7:0] v);
    clamp = v < 8'h08 ? 8'h08 : (v > 8'h14 ? 8'h14 : v);
  endfunction
  rst_src_a: assert property (
    (!external_reset_low_n_i || por_i) && ce_i |-> ##2 mode_o == 3'h0)
    else $error("reset source ignored");
  leds_soft_a: assert property (
    boost_soft_o |-> !led_enable_o) else $error("led on in soft-start");
  stby_off_a: assert property (
    mode_o == 3'h1 |-> !(blocks_on_o || boost_on_o || led_enable_o))
    else $error("function on in standby");
  run_start_a: assert property (
    wc && wdata_i[0] && mode_o == 3'h1 |-> ##3 mode_o == 3'h2)
    else $error("no startup after run");
  tsd_hold_a: assert property (
    thermal_shutdown_i && ce_i && mode_o > 3'h2 |-> ##2 mode_o <= 3'h2)
    else $error("thermal event ignored");
  soft_len_a: assert property (
    mode_o == 3'h4 && last_reg == 3'h3 && boost_on_o
    |-> run_reg >= SOFTST_CYC - 1 && run_reg <= SOFTST_CYC)
    else $error("soft-start length wrong");
  boost_off_a: assert property (
    wc && !wdata_i[1] && mode_o == 3'h4 |-> ##2 !boost_on_o)
    else $error("boost still on");
  vout_clamp_a: assert property (
    wv && mode_o == 3'h4 |-> ##2 vout_eff_o == clamp($past(wdata_i, 2)))
    else $error("voltage setting wrong");
endmodule // ldms_seq_sva
bind ldms_seq ldms_seq_sva #(.SOFTST_CYC(SOFTST_CYC)) u_sva (.*);

/* verification/tb_ldms_seq.sv */
// testbench for the led driver mode sequencer
module tb_ldms_seq;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 20;
  localparam int SF = 30;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic ext_n = 1'b1, por = 1'b0, thermal_shutdown = 1'b0;
  wire wr_en, blk, bon, bsoft, aload, led;
  wire [7:0] addr, wdata, rdata, vout;
  wire [2:0] mode;
  int n_errors = 0, checked = 0, cyc = 0;
  logic [7:0] d;
  // written byte and the clamped setting it should give
  logic [15:0] rows [7] = '{16'h0008, 16'h0708, 16'h0808, 16'h0d0d,
    16'h1414, 16'h1514, 16'hff14};
  ldms_seq #(.STARTUP_CYC(SC), .SOFTST_CYC(SF)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .external_reset_low_n_i(ext_n), .por_i(por),
    .thermal_shutdown_i(thermal_shutdown), .wr_en_i(wr_en), .addr_i(addr),
    .wdata_i(wdata), .rdata_o(rdata), .mode_o(mode),
    .blocks_on_o(blk), .boost_on_o(bon), .boost_soft_o(bsoft),
    .aload_on_o(aload), .led_enable_o(led), .vout_eff_o(vout));
  ldms_host u_host (.clk_sys_i(clk_sys_i), .wr_en_o(wr_en),
    .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
  always #10 clk_sys_i = ~clk_sys_i;
  // hang guard, well past the longest sequence
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, s);
    checked++;
    if (s !== e) begin
      $display("ERROR %s exp %h got %h", nm, e, s);
      n_errors++;
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int i;
    for (i = 0; i < 200 && mode !== m; i++) @(negedge clk_sys_i);
    chk("mode", {5'h0, m}, {5'h0, mode});
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    wait_mode(3'h1);
    u_host.rd(8'h10, d);
    chk("ctrl", 8'h04, d);
    u_host.rd(8'h33, d);
    chk("unmapped", 8'h00, d);
    chk("stby", 8'h00, {5'h0, blk, bon, led});
    u_host.wr(8'h0d, 8'h11);
    u_host.wr(8'h10, 8'h07);
    wait_mode(3'h2);
    repeat (SC - 1) @(negedge clk_sys_i);
    chk("start_len", 8'h0a, {4'h0, blk, mode});
    @(negedge clk_sys_i);
    chk("soft_entry", 8'h03, {5'h0, mode});
    chk("soft", 8'h05, {5'h0, bsoft, led, bon});
    repeat (SF - 1) @(negedge clk_sys_i);
    chk("soft_len", 8'h03, {5'h0, mode});
    @(negedge clk_sys_i);
    chk("norm_entry", 8'h04, {5'h0, mode});
    chk("norm", 8'h07, {4'h0, bsoft, led, bon, aload});
    chk("vout_eff", 8'h11, vout);
    foreach (rows[i]) begin
      u_host.wr(8'h0d, rows[i][15:8]);
      u_host.rd(8'h0d, d);
      chk("vout_reg", rows[i][15:8], d);
      chk("vout_eff", rows[i][7:0], vout);
    end
    u_host.wr(8'h10, 8'h05);
    repeat (2) @(negedge clk_sys_i);
    chk("boost_off", 8'h06, {5'h0, mode == 3'h4, led, bon});
    u_host.wr(8'h0d, 8'h08);
    @(negedge clk_sys_i);
    chk("idle_vout", 8'h08, vout);
    u_host.wr(8'h10, 8'h03);
    wait_mode(3'h3);
    wait_mode(3'h4);
    chk("aload", 8'h00, {7'h0, aload});
    thermal_shutdown = 1'b1;
    wait_mode(3'h2);
    repeat (SC * 3) @(negedge clk_sys_i);
    chk("tsd_hold", 8'h02, {5'h0, mode});
    thermal_shutdown = 1'b0;
    wait_mode(3'h3);
    thermal_shutdown = 1'b1;
    wait_mode(3'h2);
    thermal_shutdown = 1'b0;
    wait_mode(3'h3);
    wait_mode(3'h4);
    ce_i = 1'b0;
    u_host.wr(8'h10, 8'h00);
    ce_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk("frozen", 8'h04, {5'h0, mode});
    u_host.wr(8'h10, 8'h00);
    wait_mode(3'h1);
    u_host.wr(8'h0d, 8'h12);
    ext_n = 1'b0;
    u_host.wr(8'h0d, 8'h14);
    wait_mode(3'h0);
    ext_n = 1'b1;
    por = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk("por", 8'h00, {5'h0, mode});
    por = 1'b0;
    wait_mode(3'h1);
    u_host.rd(8'h0d, d);
    chk("vout_reg", 8'h08, d);
    end_sim();
  end
endmodule // tb_ldms_seq
